/* sfdpd_flash_end.sv */
// flash end: instruction capture and deep power-down state control
`timescale 1ns/10ps
`default_nettype none

module sfdpd_flash_end
    import sfdpd_pkg::*;
#(
    parameter int REL_CYC = RELEASE_CYC, // release wait, shorten for simulation
    parameter int ENT_CYC = ENTRY_CYC // entry wait, never above ENTRY_CYC
)
(
    input wire logic mclk,
    input wire logic rst_n,
    sfdpd_link_if.flash link,
    output logic in_power_down,
    output logic standby,
    output logic cmd_strobe,
    output logic [7:0] cmd_code
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic cs_s1; // first stage, read only by cs_s2
    logic cs_s2; // select, safe to use
    logic cs_d; // select one cycle later, for edge detect
    logic sck_s1; // first stage, read only by sck_s2
    logic sck_s2; // serial clock, safe to use
    logic sck_d; // serial clock one cycle later
    logic mosi_s1; // first stage, read only by mosi_s2
    logic mosi_s2; // data, delayed like the clock

    // all link pins come from another timing domain, two flops each
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end
        else
        begin
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            sck_s1 <= link.sclk;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            mosi_s1 <= link.mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    logic sck_rise; // bit latch moment
    logic cs_rise; // end of a frame

    // data and clock pass equal delays, so data is sampled where the host meant
    assign sck_rise = sck_s2 & ~sck_d;
    assign cs_rise = cs_s2 & ~cs_d;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction shifter

    logic [7:0] shreg; // instruction bits, msb first
    logic [BIT_CNT_W-1:0] bit_cnt; // bits latched in this frame

    // shift on each serial clock rise while selected
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            shreg <= 8'h00;
            bit_cnt <= '0;
        end
        else if (cs_s2)
        begin
            // deselected: next frame starts from zero
            bit_cnt <= '0;
        end
        else if (sck_rise)
        begin
            shreg <= {shreg[6:0], mosi_s2}; // R1 R7
            // saturate so that a long frame never wraps back to eight
            if (bit_cnt != BIT_CNT_OVER)
            begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    logic frame_ok; // a whole single-byte instruction just ended

    // select must rise with exactly eight bits in, else nothing executes
    assign frame_ok = cs_rise && (bit_cnt == BIT_CNT_FULL); // R2

    ////////////////////////////////////////////////////////////////////////////////
    // operating state

    sfdpd_flash_state_e state; // current operating state
    logic [TMR_W-1:0] tmr; // entry and release wait
    logic rst_armed; // reset-enable byte seen last frame

    // state moves only at frame ends or on timer expiry
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            // power-up always lands in normal standby
            state <= FS_NORMAL; // R6
            tmr <= '0;
        end
        else
        begin
            case (state)
                FS_NORMAL:
                begin
                    tmr <= '0;
                    // release byte here is harmless and falls through
                    if (frame_ok && shreg == OP_POWER_DOWN) // R1 R13
                    begin
                        state <= FS_ENTER;
                    end
                end
                FS_ENTER:
                begin
                    // instructions during entry are dropped; host waits it out
                    if (tmr == TMR_W'(ENT_CYC - 1)) // R3 R4
                    begin
                        state <= FS_DPD;
                        tmr <= '0;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                FS_DPD:
                begin
                    tmr <= '0;
                    // only release and the two reset forms are heard
                    if (frame_ok)
                    begin
                        if (shreg == OP_RELEASE) // R5 R7
                        begin
                            state <= FS_RELEASE;
                        end
                        else if (shreg == OP_RESET) // R5
                        begin
                            state <= FS_NORMAL;
                        end
                        else if (shreg == OP_RESET_PAIR && rst_armed) // R5
                        begin
                            state <= FS_NORMAL;
                        end
                    end
                end
                FS_RELEASE:
                begin
                    // nothing is accepted until the release wait ends
                    if (tmr == TMR_W'(REL_CYC - 1)) // R8 R9
                    begin
                        state <= FS_NORMAL;
                        tmr <= '0;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                default:
                begin
                    // an illegal code falls back to the safe state
                    state <= FS_NORMAL;
                    tmr <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset-enable tracking

    // the pair must come in two back-to-back frames; any other frame disarms
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rst_armed <= 1'b0;
        end
        else if (frame_ok && (state == FS_NORMAL || state == FS_DPD))
        begin
            rst_armed <= (shreg == OP_RESET_ENABLE); // R5
        end
        else if (cs_rise)
        begin
            // a malformed frame breaks the pair as well
            rst_armed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // user-side outputs

    // every whole instruction heard in normal operation is reported once
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cmd_strobe <= 1'b0;
            cmd_code <= 8'h00;
        end
        else if (frame_ok && state == FS_NORMAL)
        begin
            cmd_strobe <= 1'b1;
            cmd_code <= shreg;
        end
        else
        begin
            // code holds until the next instruction
            cmd_strobe <= 1'b0;
        end
    end

    // state bits are flops, so these follow the state register directly
    assign in_power_down = (state == FS_DPD);
    assign standby = (state == FS_NORMAL);

endmodule // sfdpd_flash_end

`default_nettype wire

/* sfdpd_pkg.sv */
// shared constants and types for the deep power-down link, both ends
//
// Notes on behaviour
// R1: power-down entry is select low plus one opcode
// R2: select must rise right after bit eight
// R3: power-down state reached within entry time
// R4: entry time at most three microseconds
// R5: in power-down only release and resets heard
// R6: power-up always starts in normal standby
// R7: release is select low, one opcode, select high
// R8: wait release time before accepting instructions again
// R9: release time at most one and half milliseconds
// R10: host keeps select high through release time
// R11: host waits 200 us before first select
// R12: host waits 1 ms before any write
// R13: release in normal operation changes nothing
`default_nettype none

package sfdpd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction codes
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9; // enter deep power-down
    localparam logic [7:0] OP_RELEASE = 8'hab; // release from power-down
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66; // first half of reset pair
    localparam logic [7:0] OP_RESET_PAIR = 8'h99; // second half of reset pair
    localparam logic [7:0] OP_RESET = 8'hff; // single-byte reset

    ////////////////////////////////////////////////////////////////////////////////
    // framing
    localparam int OP_BITS = 8; // bits in one instruction
    localparam int BIT_CNT_W = 4; // bit counter, saturates above OP_BITS
    localparam logic [3:0] BIT_CNT_FULL = 4'h8; // exactly one whole byte
    localparam logic [3:0] BIT_CNT_OVER = 4'h9; // more than one byte seen

    ////////////////////////////////////////////////////////////////////////////////
    // timing, times in ns as printed, counts derived at 100 MHz
    localparam int CLK_PERIOD_NS = 10; // mclk period
    localparam int ENTRY_TIME_NS = 3000; // power_down_entry_time, longest
    localparam int RELEASE_TIME_NS = 1500000; // release time, longest
    localparam int SELECT_DELAY_NS = 200000; // supply_to_select_delay, least
    localparam int WRITE_DELAY_NS = 1000000; // power_up_write_delay, least
    // longest times round down, least times round up
    localparam int ENTRY_CYC = ENTRY_TIME_NS / CLK_PERIOD_NS;
    localparam int RELEASE_CYC = RELEASE_TIME_NS / CLK_PERIOD_NS;
    localparam int SELECT_DELAY_CYC = (SELECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_DELAY_CYC = (WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_CYC = 4; // serial clock half period in mclk cycles
    localparam int TMR_W = 18; // wide enough for the longest count

    ////////////////////////////////////////////////////////////////////////////////
    // flash end operating states, one-hot
    typedef enum logic [3:0] {
        FS_NORMAL = 4'h1,
        FS_ENTER = 4'h2,
        FS_DPD = 4'h4,
        FS_RELEASE = 4'h8
    } sfdpd_flash_state_e;

    // host end sequencing states, one-hot
    typedef enum logic [5:0] {
        HS_PWRUP = 6'h01,
        HS_IDLE = 6'h02,
        HS_LOW = 6'h04,
        HS_HIGH = 6'h08,
        HS_GAP = 6'h10,
        HS_HOLD = 6'h20
    } sfdpd_host_state_e;

endpackage

`default_nettype wire

/* sfdpd_link_if.sv */
// serial link between host controller and flash end
`timescale 1ns/10ps
`default_nettype none

interface sfdpd_link_if;
    logic cs_n; // chip select, active low
    logic sclk; // serial clock from host
    logic mosi; // serial data host to flash

    // host drives the whole link
    modport host (output cs_n, output sclk, output mosi);
    // flash only listens
    modport flash (input cs_n, input sclk, input mosi);
endinterface

`default_nettype wire

/* sfdpd_host_end.sv */
// host end: power-up waits and single-byte instruction sender
`timescale 1ns/10ps
`default_nettype none

module sfdpd_host_end
    import sfdpd_pkg::*;
#(
    parameter int SEL_CYC = SELECT_DELAY_CYC, // wait before first select
    parameter int WR_CYC = WRITE_DELAY_CYC, // wait before first write
    parameter int REL_CYC = RELEASE_CYC, // select held high after release
    parameter int ENT_CYC = ENTRY_CYC, // select held high after power-down
    parameter int HALF_CYC = SCK_HALF_CYC // serial clock half period, at least 3
)
(
    input wire logic mclk,
    input wire logic rst_n,
    sfdpd_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_write,
    output logic cmd_ready,
    output logic cmd_done,
    output logic link_ready,
    output logic write_ok
);

    ////////////////////////////////////////////////////////////////////////////////
    // write permission after power-up

    logic [TMR_W-1:0] wr_cnt; // cycles since reset release, saturating

    // writes are refused until the write delay has passed
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_cnt <= '0;
            write_ok <= 1'b0;
        end
        else if (wr_cnt == TMR_W'(WR_CYC - 1))
        begin
            write_ok <= 1'b1; // R12
        end
        else
        begin
            wr_cnt <= wr_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sender

    sfdpd_host_state_e state; // sequencing state
    logic [TMR_W-1:0] tmr; // phase and hold timer
    logic [TMR_W-1:0] hold_len; // hold length for the frame just sent
    logic [7:0] sh; // bits still to send, msb first
    logic [7:0] op; // byte of the frame in flight
    logic [2:0] bit_idx; // bit being sent

    // one frame per request: select low, eight clocks, select high
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= HS_PWRUP;
            tmr <= '0;
            hold_len <= '0;
            sh <= 8'h00;
            op <= 8'h00;
            bit_idx <= 3'h0;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
            cmd_done <= 1'b0;
        end
        else
        begin
            cmd_done <= 1'b0;
            case (state)
                HS_PWRUP:
                begin
                    // select stays high until the supply has settled
                    if (tmr == TMR_W'(SEL_CYC - 1)) // R11
                    begin
                        state <= HS_IDLE;
                        tmr <= '0;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                HS_IDLE:
                begin
                    if (cmd_valid && cmd_ready)
                    begin
                        link.cs_n <= 1'b0; // R1 R7
                        link.mosi <= cmd_byte[7];
                        sh <= {cmd_byte[6:0], 1'b0};
                        op <= cmd_byte;
                        bit_idx <= 3'h0;
                        tmr <= '0;
                        state <= HS_LOW;
                    end
                end
                HS_LOW:
                begin
                    if (tmr == TMR_W'(HALF_CYC - 1))
                    begin
                        link.sclk <= 1'b1;
                        tmr <= '0;
                        state <= HS_HIGH;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                HS_HIGH:
                begin
                    if (tmr == TMR_W'(HALF_CYC - 1))
                    begin
                        link.sclk <= 1'b0;
                        tmr <= '0;
                        if (bit_idx == 3'(OP_BITS - 1))
                        begin
                            // deselect at once after the eighth bit
                            link.cs_n <= 1'b1; // R2
                            state <= HS_GAP;
                        end
                        else
                        begin
                            link.mosi <= sh[7];
                            sh <= {sh[6:0], 1'b0};
                            bit_idx <= bit_idx + 1'b1;
                            state <= HS_LOW;
                        end
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                HS_GAP:
                begin
                    // short deselect so the far end sees the select edge
                    tmr <= '0;
                    state <= HS_HOLD;
                    if (op == OP_RELEASE)
                    begin
                        hold_len <= TMR_W'(REL_CYC); // R10
                    end
                    else if (op == OP_POWER_DOWN)
                    begin
                        hold_len <= TMR_W'(ENT_CYC);
                    end
                    else
                    begin
                        hold_len <= TMR_W'(2 * HALF_CYC);
                    end
                end
                HS_HOLD:
                begin
                    // select is kept high for the whole hold
                    if (tmr >= hold_len)
                    begin
                        cmd_done <= 1'b1;
                        tmr <= '0;
                        state <= HS_IDLE;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1; // R10
                    end
                end
                default:
                begin
                    link.cs_n <= 1'b1;
                    link.sclk <= 1'b0;
                    tmr <= '0;
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // handshake outputs are combinational
    assign link_ready = (state != HS_PWRUP);
    assign cmd_ready = (state == HS_IDLE) && (!cmd_write || write_ok); // R12

endmodule // sfdpd_host_end

`default_nettype wire

/* sfdpd_sva.sv */
// checker for the deep power-down link and the flash end state outputs
`timescale 1ns/10ps
`default_nettype none

module sfdpd_sva
#(
    parameter int REL_CYC = 200, // release wait, as given to both ends
    parameter int ENT_CYC = 10 // entry wait, as given to both ends
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic in_power_down,
    input wire logic standby,
    input wire logic cmd_strobe,
    input wire logic cmd_write,
    input wire logic cmd_ready,
    input wire logic link_ready,
    input wire logic write_ok
);
    localparam int ENT_MAX = 300; // entry bound, 3 us at 100 MHz
    localparam int REL_LO = REL_CYC - 2; // slack for the select synchroniser
    localparam int REL_HI = REL_CYC + 2;

    ////////////////////////////////////////////////////////////////////////////////
    // helper counters
    logic [3:0] since_rise; // edges since select went high, saturating
    logic [17:0] rel_cnt; // edges spent neither in standby nor power-down

    // cleared while selected so it measures the reaction to a deselect
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !cs_n)
            since_rise <= 4'h0;
        else if (since_rise != 4'hf)
            since_rise <= since_rise + 4'h1;
    end

    // counts entry and release; cleared once power-down is reached
    always_ff @(posedge mclk)
    begin
        if (!rst_n || standby || in_power_down)
            rel_cnt <= 18'h00000;
        else
            rel_cnt <= rel_cnt + 18'h00001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence enter_s;
        $fell(standby) && !in_power_down;
    endsequence

    sequence leave_s;
        $fell(in_power_down) && !standby;
    endsequence

    reset_state_a: assert property (disable iff (1'b0) !rst_n |=> standby && !in_power_down && cs_n)
        else $error("state after reset is not normal standby");
    state_excl_a: assert property (!(standby && in_power_down))
        else $error("standby and power-down both high");
    entry_time_a: assert property (enter_s |-> !standby throughout (##[1:ENT_MAX] in_power_down))
        else $error("power-down not reached within entry time");
    leave_time_a: assert property ($rose(standby) && !$past(in_power_down) |-> rel_cnt inside {[REL_LO:REL_HI]})
        else $error("release time wrong");
    react_time_a: assert property (($fell(standby) or leave_s or cmd_strobe) |-> cs_n && since_rise inside {[1:5]})
        else $error("reaction not tied to select rising");
    quiet_dpd_a: assert property (in_power_down |-> !cmd_strobe)
        else $error("instruction accepted in power-down");
    strobe_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("strobe longer than one cycle");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    select_wait_a: assert property (!link_ready |-> cs_n)
        else $error("select low during power-up wait");
    write_wait_a: assert property (cmd_write && !write_ok |-> !cmd_ready)
        else $error("write accepted too early");
    release_hold_a: assert property (leave_s |-> cs_n [*8])
        else $error("select fell during release");
endmodule // sfdpd_sva

`default_nettype wire

/* sfdpd_tb_top.sv */
// self-checking testbench: host end facing flash end, plus a rule-breaking link
`timescale 1ns/10ps
`default_nettype none

module sfdpd_tb_top
    import sfdpd_pkg::*;
;
    localparam int REL = 200; // shortened release wait
    localparam int ENT = 10; // shortened entry wait
    localparam int SEL = 20; // shortened select wait
    localparam int WR = 100; // shortened write wait
    localparam int HALF = 4; // serial clock half period
    localparam int FRAME = 16 * HALF + 1; // eight bits plus the gap

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic cmd_write = 1'b0;
    logic cmd_ready;
    logic cmd_done;
    logic link_ready;
    logic write_ok;
    logic in_power_down;
    logic standby;
    logic cmd_strobe;
    logic [7:0] cmd_code;
    logic ipd_b; // power-down flag of the second flash end
    int failures = 0;
    int cmp_count = 0;
    logic [7:0] wire_sh = 8'h00; // bits seen on the wire, msb first
    int wire_bits = 0;
    int strobes = 0;
    logic [7:0] last_code = 8'h00;
    logic sclk_q = 1'b0;
    int n;
    int s;
    logic [7:0] dpd_ops [4] = '{8'h05, 8'h0f, OP_RESET_PAIR, OP_POWER_DOWN};

    sfdpd_link_if link();
    sfdpd_link_if link_b();
    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // design instances
    sfdpd_host_end #(.SEL_CYC(SEL), .WR_CYC(WR), .REL_CYC(REL), .ENT_CYC(ENT), .HALF_CYC(HALF))
    u_sfdpd_host_end (.mclk(mclk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_write(cmd_write), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .link_ready(link_ready), .write_ok(write_ok));
    sfdpd_flash_end #(.REL_CYC(REL), .ENT_CYC(ENT))
    u_sfdpd_flash_end (.mclk(mclk), .rst_n(rst_n), .link(link), .in_power_down(in_power_down),
        .standby(standby), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code));
    // second flash end, its link driven by the bench
    sfdpd_flash_end #(.REL_CYC(REL), .ENT_CYC(ENT))
    u_sfdpd_flash_end_b (.mclk(mclk), .rst_n(rst_n), .link(link_b), .in_power_down(ipd_b),
        .standby(), .cmd_strobe(), .cmd_code());
    sfdpd_sva #(.REL_CYC(REL), .ENT_CYC(ENT))
    u_sfdpd_sva (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .in_power_down(in_power_down), .standby(standby), .cmd_strobe(cmd_strobe),
        .cmd_write(cmd_write), .cmd_ready(cmd_ready), .link_ready(link_ready),
        .write_ok(write_ok));

    ////////////////////////////////////////////////////////////////////////////////
    // wire monitor: shifts on serial clock rise while selected, logs strobes
    always @(posedge mclk)
    begin
        sclk_q <= link.sclk;
        if (!link.cs_n && link.sclk && !sclk_q)
        begin
            wire_sh <= {wire_sh[6:0], link.mosi};
            wire_bits <= wire_bits + 1;
        end
        if (cmd_strobe)
        begin
            strobes <= strobes + 1;
            last_code <= cmd_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // select hold that the host keeps after each opcode
    function automatic int hold_of(input logic [7:0] op);
        if (op == OP_RELEASE)
            return REL;
        if (op == OP_POWER_DOWN)
            return ENT;
        return 2 * HALF;
    endfunction

    // one request through the host port; checks latency and the wire byte
    task automatic send(input logic [7:0] op, input logic wr);
        int t;
        t = 0;
        cmd_write = wr;
        #1;
        while (!cmd_ready && t < 2000)
        begin
            @(negedge mclk);
            t++;
        end
        cmd_byte = op;
        cmd_valid = 1'b1;
        wire_bits = 0;
        @(negedge mclk);
        cmd_valid = 1'b0;
        t = 0;
        while (!cmd_done && t < 2000)
        begin
            @(negedge mclk);
            t++;
        end
        check(t, FRAME + hold_of(op) + 1);
        check(wire_sh, op);
        check(wire_bits, 8);
    endtask

    // bounded wait for the flash end to return to standby
    task automatic wait_standby();
        int t;
        t = 0;
        while (!standby && t < REL + 20)
        begin
            @(negedge mclk);
            t++;
        end
    endtask

    // bench-made frame of nb bits on the second link
    task automatic bang(input logic [8:0] v, input int nb);
        link_b.cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--)
        begin
            link_b.mosi = v[i];
            repeat (HALF) @(negedge mclk);
            link_b.sclk = 1'b1;
            repeat (HALF) @(negedge mclk);
            link_b.sclk = 1'b0;
        end
        // a released line must not keep showing the last bit
        link_b.mosi = ~link_b.mosi;
        repeat (2) @(negedge mclk);
        link_b.cs_n = 1'b1;
        repeat (ENT + 10) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.mosi = 1'b0;
        repeat (12) @(negedge mclk);
        check(standby, 1'b1);
        check(in_power_down, 1'b0);
        rst_n = 1'b1;
        n = 0;
        while (!link_ready && n < 500)
        begin
            @(negedge mclk);
            n++;
        end
        check(n, SEL);
        cmd_write = 1'b1;
        #1;
        check(cmd_ready, 1'b0);
        @(negedge mclk);
        n++;
        cmd_write = 1'b0;
        while (!write_ok && n < 500)
        begin
            @(negedge mclk);
            n++;
        end
        check(n, WR);
        // normal operation: everything strobed, release changes nothing
        foreach (dpd_ops[i])
        begin
            s = strobes;
            send(dpd_ops[i] ^ {7'h00, i[0]}, 1'b0);
            check(strobes, s + 1);
        end
        send(OP_RELEASE, 1'b1);
        check(last_code, OP_RELEASE);
        check(standby, 1'b1);
        // power-down, then only release and resets are heard
        send(OP_POWER_DOWN, 1'b0);
        repeat (5) @(negedge mclk);
        check(in_power_down, 1'b1);
        s = strobes;
        foreach (dpd_ops[i])
            send(dpd_ops[i], 1'b0);
        check(strobes, s);
        check(in_power_down, 1'b1);
        send(OP_RELEASE, 1'b0);
        check(standby, 1'b0);
        wait_standby();
        check(standby, 1'b1);
        send(8'h05, 1'b0);
        check(last_code, 8'h05);
        send(OP_POWER_DOWN, 1'b0);
        send(OP_RESET, 1'b0);
        wait_standby();
        check(standby, 1'b1);
        send(OP_POWER_DOWN, 1'b0);
        send(OP_RESET_ENABLE, 1'b0);
        send(8'h05, 1'b0);
        send(OP_RESET_PAIR, 1'b0);
        check(in_power_down, 1'b1);
        send(OP_RESET_ENABLE, 1'b0);
        send(OP_RESET_PAIR, 1'b0);
        wait_standby();
        check(standby, 1'b1);
        // framing faults on the second link: nine and seven bits ignored
        bang(9'h1b9, 9);
        check(ipd_b, 1'b0);
        bang(9'h039, 7);
        check(ipd_b, 1'b0);
        bang({1'b0, OP_POWER_DOWN}, 8);
        check(ipd_b, 1'b1);
        summarize();
    end

    // watchdog: the sequence needs well under 15000 cycles
    initial
    begin
        #400000;
        failures++;
        $display("[FAIL] t=%0t seen=%h expected=%h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule // sfdpd_tb_top

`default_nettype wire
